/* File: src/texld_addr_calc.sv */
`timescale 1ns/100ps
module texld_addr_calc (
    texld_tex_if.calc x
);
    // size exponent of one level in 16-bit 8-byte units
    function automatic logic [3:0] texld_level_exp(
        input logic [3:0] lod,
        input logic [1:0] asp
    );
        logic [5:0] sub;
        logic [3:0] e;
        logic [3:0] fl;
        sub = {1'b0, lod, 1'b0} + {4'h0, asp};
        e = (sub > texld_pkg::EXP_TOP) ? 4'h0 :
            4'(texld_pkg::EXP_TOP - sub);
        fl = (lod == texld_pkg::LOD_F5) ? texld_pkg::FLOOR_F5 :
             (lod == texld_pkg::LOD_F6) ? texld_pkg::FLOOR_F6 : 4'h0;
        return (e > fl) ? e : fl;
    endfunction

    // level sizes in 4-byte words, so an 8-bit half location is one word
    logic [15:0] lvl_words [texld_pkg::LEVELS];
    genvar g;
    generate
        for (g = 0; g < texld_pkg::LEVELS; g++) begin : g_lvl
            logic [3:0] e;
            assign e = texld_level_exp(4'(g), x.aspect);
            assign lvl_words[g] = x.fmt8 ? 16'h0001 << e :
                16'h0002 << e;
        end
    endgenerate

    // field decode, coordinates right aligned
    logic seq;
    assign seq = x.seq8 && x.fmt8;
    assign x.lod = x.addr[texld_pkg::LOD_LO +: 4];
    assign x.t = x.addr[texld_pkg::T_LO +: 8];
    always_comb begin
        if (seq)
            x.s = {x.addr[texld_pkg::S_LO +: 6], 2'h0};
        else if (x.fmt8)
            x.s = {x.addr[texld_pkg::S_LO + 1 +: 6], 2'h0};
        else
            x.s = {x.addr[texld_pkg::S_LO +: 7], 1'b0};
    end

    // start of the level: lod 0 first, smaller ones packed after it; split counts only lod_odd parity levels
    logic [20:0] start;
    always_comb begin
        start = 21'h000000;
        for (int l = 0; l < texld_pkg::LEVELS; l++) begin
            if (4'(l) < x.lod && (!x.tsplit || 1'(l) == x.lod_odd))
                start = start + 21'(lvl_words[l]);
        end
    end

    // row pitch in texels and byte offset inside the level
    logic [4:0] shift;
    logic [8:0] ws;
    logic [16:0] pix;
    logic [17:0] boff;
    assign shift = x.s_wider ? {1'b0, x.lod} :
        {1'b0, x.lod} + {3'h0, x.aspect};
    assign ws = (shift >= 5'h08) ? 9'h001 : 9'h100 >> shift;
    assign pix = 17'({9'h000, x.t} * {8'h00, ws}) + {9'h000, x.s};
    assign boff = x.fmt8 ? {1'b0, pix} : {pix, 1'b0};
    // base counts 8-byte units; sum wraps at the window width
    assign x.word = {x.base, 1'b0} + start + 21'(boff[17:2]);
    assign x.byte_off = boff[1:0];
    assign x.narrow = (ws == 9'h001) ? texld_pkg::NARROW_ONE :
        (ws == 9'h002) ? texld_pkg::NARROW_TWO : 2'h0;
endmodule

/* File: src/texld_lane_pack.sv */
`timescale 1ns/100ps
module texld_lane_pack (
    texld_tex_if.pack x
);
    logic [3:0] keep;
    // 1-wide maps and 2-wide 8-bit maps keep only the low texel lanes
    always_comb begin
        if (x.narrow == texld_pkg::NARROW_ONE)
            keep = x.fmt8 ? 4'h1 : 4'h3;
        else if (x.narrow == texld_pkg::NARROW_TWO && x.fmt8)
            keep = 4'h3;
        else
            keep = 4'hF;
    end
    // narrow rows share a word, so lanes slide to the row's byte
    assign x.be = 4'(keep << x.byte_off);
    assign x.data = x.wdata << {x.byte_off, 3'h0};
endmodule

/* File: src/texld_pkg.sv */
package texld_pkg;
    // host window: bit 23 clear = control registers, set = texture memory
    localparam int WIN_BIT = 23;
    localparam int BASE_W = 20;
    localparam int WORD_W = 21;
    localparam int LEVELS = 9;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // control register byte offsets
    localparam logic [23:0] OFS_BASE = 24'h000000;
    localparam logic [23:0] OFS_MODE = 24'h000004;
    localparam logic [23:0] OFS_INIT_A = 24'h000008;
    localparam logic [23:0] OFS_INIT_B = 24'h00000C;
    localparam logic [23:0] OFS_STATUS = 24'h000010;
    localparam logic [23:0] OFS_LAST = 24'h000014;
    // mode register fields
    localparam int MODE_W = 9;
    localparam int M_FMT8 = 0;
    localparam int M_SEQ8 = 1;
    localparam int M_ODD = 2;
    localparam int M_SPLIT = 3;
    localparam int M_ASP = 4;
    localparam int M_SWIDE = 6;
    localparam int M_CLS = 7;
    localparam int M_CLT = 8;
    localparam int INIT_A_UNIT = 0;
    localparam int INIT_B_LEGACY = 0;
    // texture byte address fields
    localparam int UNIT_LO = 21;
    localparam int LOD_LO = 17;
    localparam int T_LO = 9;
    localparam int S_LO = 2;
    // level size table shape
    localparam logic [5:0] EXP_TOP = 6'h0E;
    localparam logic [3:0] LOD_F5 = 4'h5;
    localparam logic [3:0] LOD_F6 = 4'h6;
    localparam logic [3:0] FLOOR_F5 = 4'h2;
    localparam logic [3:0] FLOOR_F6 = 4'h1;
    localparam logic [1:0] NARROW_ONE = 2'h1;
    localparam logic [1:0] NARROW_TWO = 2'h2;
    // reset values
    localparam logic [19:0] RST_BASE = 20'h00000;
    localparam logic [8:0] RST_MODE = 9'h000;
    localparam logic [31:0] RST_INIT = 32'h00000000;
endpackage

/* File: src/texld_tex_if.sv */
`timescale 1ns/100ps
interface texld_tex_if;
    logic fmt8, seq8, lod_odd, tsplit, s_wider;
    logic [1:0] aspect;
    logic [19:0] base;
    logic [22:0] addr;
    logic [31:0] wdata;
    logic [3:0] lod;
    logic [7:0] s, t;
    logic [20:0] word;
    logic [1:0] narrow, byte_off;
    logic [3:0] be;
    logic [31:0] data;
    modport top(output fmt8, seq8, lod_odd, tsplit, s_wider, aspect, base,
        addr, wdata, input lod, s, t, word, narrow, byte_off, be, data);
    modport calc(input fmt8, seq8, lod_odd, tsplit, s_wider, aspect, base,
        addr, output lod, s, t, word, narrow, byte_off);
    modport pack(input fmt8, wdata, narrow, byte_off, output be, data);
endinterface

/* File: src/texld_top.sv */
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
// Notes on behaviour
// - texel address is base plus offset from lod, s, t and mode
// - 16-bit level sizes follow the lod and aspect table
// - 8-bit level sizes are half the 16-bit ones
// - levels pack into free halves; textures never share a half
// - base counts in 8-byte units, level sizes in 4-byte words
// - base may sit below zero; the sum wraps modulo address width
// - one write carries two 16-bit or four 8-bit texels
// - 16-bit: low half s0 clear, high half s0 set; 1-wide drops top
// - 8-bit: lane k holds texel s=k; 2-wide and 1-wide drop lanes
// - plain decode: unit 22:21, lod 20:17, t 16:9, s 8:2
// - plain decode of an 8-bit texture forces s bit 1 to zero
// - small maps right aligned: s at bit 2, t at bit 9
// - sequential 8-bit decode: t 16:9, s 7:2; absent on legacy part
// - i/o space cycles are ignored
// - lod 0 first, smaller levels packed contiguously after it; split mode counts only levels of the lod_odd parity
// - texture window is write only; reads return zero
module texld_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [23:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic host_io_cycle,
    output logic tex_we,
    output logic [19:0] tex_addr,
    output logic tex_half,
    output logic [3:0] tex_be,
    output logic [31:0] tex_data
);
    typedef struct packed {
        logic dp_act;
        logic dp_write;
        logic dp_tex;
        logic [23:0] dp_addr;
        logic rd_wait;
        logic [31:0] rdata;
        logic [19:0] base;
        logic [8:0] mode;
        logic [31:0] init_a;
        logic [31:0] init_b;
        logic [15:0] wr_count;
        logic tex_we;
        logic [19:0] tex_addr;
        logic tex_half;
        logic [3:0] tex_be;
        logic [31:0] tex_data;
    } texld_state_t;

    texld_state_t st;
    texld_state_t next_st;

    texld_tex_if tx();

    texld_addr_calc u_calc (
        .x(tx)
    );

    texld_lane_pack u_pack (
        .x(tx)
    );

    // register read decode
    function automatic logic [31:0] texld_read(
        input texld_state_t r
    );
        logic [31:0] v;
        v = 32'h00000000;
        if (!r.dp_tex) begin
            case (r.dp_addr)
                texld_pkg::OFS_BASE: v = {12'h000, r.base};
                texld_pkg::OFS_MODE: v = {23'h000000, r.mode};
                texld_pkg::OFS_INIT_A: v = r.init_a;
                texld_pkg::OFS_INIT_B: v = r.init_b;
                texld_pkg::OFS_STATUS: v = {16'h0000, r.wr_count};
                texld_pkg::OFS_LAST: v = {11'h000, r.tex_addr, r.tex_half};
                default: v = 32'h00000000;
            endcase
        end
        return v;
    endfunction

    // address phase qualification
    logic addr_valid;
    logic size_ok;
    logic take;
    logic dp_done;
    logic unit_ok;
    logic tex_ok;
    assign addr_valid = hsel && hready && htrans[1];
    assign size_ok = hsize == texld_pkg::HSIZE_WORD &&
        haddr[1:0] == 2'h0;
    assign take = addr_valid && !host_io_cycle && size_ok;
    assign dp_done = st.dp_act && hready;
    // only writes addressed to this unit reach texture memory
    assign unit_ok = st.dp_addr[texld_pkg::UNIT_LO +: 2] ==
        st.init_a[texld_pkg::INIT_A_UNIT +: 2];
    assign tex_ok = dp_done && st.dp_write && st.dp_tex && unit_ok;

    // configuration toward the address and lane logic
    assign tx.fmt8 = st.mode[texld_pkg::M_FMT8];
    // legacy parts lack the sequential layout, so the bit is masked
    assign tx.seq8 = st.mode[texld_pkg::M_SEQ8] &&
        !st.init_b[texld_pkg::INIT_B_LEGACY];
    assign tx.lod_odd = st.mode[texld_pkg::M_ODD];
    assign tx.tsplit = st.mode[texld_pkg::M_SPLIT];
    assign tx.aspect = st.mode[texld_pkg::M_ASP +: 2];
    assign tx.s_wider = st.mode[texld_pkg::M_SWIDE];
    assign tx.base = st.base;
    assign tx.addr = st.dp_addr[22:0];
    assign tx.wdata = hwdata;

    // next state
    always_comb begin
        next_st = st;
        next_st.tex_we = 1'b0;
        // capture a new address phase whenever the bus is ready
        if (hready) begin
            next_st.dp_act = take;
            next_st.dp_write = hwrite;
            next_st.dp_tex = haddr[texld_pkg::WIN_BIT];
            next_st.dp_addr = haddr;
            next_st.rd_wait = take && !hwrite;
        end
        // one wait state lets a read see a write just finished
        if (st.rd_wait) begin
            next_st.rdata = texld_read(st);
            next_st.rd_wait = 1'b0;
        end
        if (dp_done && st.dp_write && !st.dp_tex) begin
            case (st.dp_addr)
                texld_pkg::OFS_BASE:
                    next_st.base = hwdata[19:0];
                texld_pkg::OFS_MODE:
                    next_st.mode = hwdata[8:0];
                texld_pkg::OFS_INIT_A:
                    next_st.init_a = hwdata;
                texld_pkg::OFS_INIT_B:
                    next_st.init_b = hwdata;
                default: ;
            endcase
        end
        // texel write: all enabled lanes commit in one cycle
        if (tex_ok) begin
            next_st.tex_we = 1'b1;
            next_st.tex_addr = tx.word[20:1];
            next_st.tex_half = tx.word[0];
            next_st.tex_be = tx.be;
            next_st.tex_data = tx.data;
            next_st.wr_count = st.wr_count + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.base <= texld_pkg::RST_BASE;
            st.mode <= texld_pkg::RST_MODE;
            st.init_a <= texld_pkg::RST_INIT;
            st.init_b <= texld_pkg::RST_INIT;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign hreadyout = !st.rd_wait;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign tex_we = st.tex_we;
    assign tex_addr = st.tex_addr;
    assign tex_half = st.tex_half;
    assign tex_be = st.tex_be;
    assign tex_data = st.tex_data;

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    io_cycle_ignore_a: assert property (
        addr_valid && host_io_cycle |=> !st.dp_act && hreadyout)
        else $error("i/o cycle was accepted");

    word_only_a: assert property (
        addr_valid && !size_ok |=> !st.dp_act)
        else $error("non word access was accepted");

    tex_commit_a: assert property (
        tex_ok |=> tex_we && tex_addr == $past(tx.word[20:1]) &&
            tex_data == $past(tx.data))
        else $error("texel write not committed next cycle");

    lane_16_a: assert property (
        tex_ok && !tx.fmt8 |=> tex_be inside {4'h3, 4'hC, 4'hF})
        else $error("16-bit write used odd byte enables");

    lane_8_one_a: assert property (
        tex_ok && tx.fmt8 && tx.narrow == texld_pkg::NARROW_ONE
        |=> $onehot(tex_be))
        else $error("1-wide 8-bit map wrote more than one lane");

    lod0_first_a: assert property (
        st.dp_tex && tx.lod == 4'h0 && tx.s == 8'h00 && tx.t == 8'h00
        |-> tx.word == {tx.base, 1'b0})
        else $error("lod 0 does not start at the base");

    lod1_16_a: assert property (
        st.dp_tex && !tx.fmt8 && !tx.tsplit && tx.aspect == 2'h0 &&
        tx.lod == 4'h1 && tx.s == 8'h00 && tx.t == 8'h00
        |-> tx.word == {tx.base, 1'b0} + 21'h008000)
        else $error("16-bit lod 1 start is wrong");

    lod1_8_a: assert property (
        st.dp_tex && tx.fmt8 && !tx.tsplit && tx.aspect == 2'h0 &&
        tx.lod == 4'h1 && tx.s == 8'h00 && tx.t == 8'h00
        |-> tx.word == {tx.base, 1'b0} + 21'h004000)
        else $error("8-bit lod 1 start is wrong");

    s_low_zero_a: assert property (
        st.dp_tex && tx.fmt8 |-> tx.s[1:0] == 2'h0)
        else $error("8-bit s low bits not cleared");

    tex_read_a: assert property (
        st.rd_wait && st.dp_tex |=> hreadyout && hrdata == 32'h00000000)
        else $error("texture read returned data");

    read_wait_a: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state is not one cycle");

    count_step_a: assert property (
        tex_ok |=> st.wr_count == $past(st.wr_count) + 16'h0001)
        else $error("write counter missed a texel write");

    // texel port: memory may latch outputs, so they hold between pulses
    unit_drop_a: assert property (
        dp_done && st.dp_write && st.dp_tex && !unit_ok
        |=> !tex_we)
        else $error("write for another unit reached memory");

    io_no_write_a: assert property (
        addr_valid && host_io_cycle
        |=> ##1 !tex_we)
        else $error("i/o cycle wrote texture memory");

    we_source_a: assert property (
        tex_we
        |-> $past(tex_ok))
        else $error("texel pulse without an accepted write");

    tex_hold_a: assert property (
        !tex_ok
        |=> !tex_we && $stable(tex_addr) && $stable(tex_half) &&
            $stable(tex_be) && $stable(tex_data))
        else $error("texel outputs moved without a write");

    count_hold_a: assert property (
        !tex_ok
        |=> $stable(st.wr_count))
        else $error("write counter moved without a write");

    // lane enables against the map width
    full_lanes_a: assert property (
        tex_ok && tx.narrow == 2'h0
        |=> tex_be == 4'hF)
        else $error("wide map lost a byte lane");

    lane_16_one_a: assert property (
        tex_ok && !tx.fmt8 && tx.narrow == texld_pkg::NARROW_ONE
        |=> tex_be inside {4'h3, 4'hC})
        else $error("1-wide 16-bit map wrote both halves");

    lane_8_two_a: assert property (
        tex_ok && tx.fmt8 && tx.narrow == texld_pkg::NARROW_TWO
        |=> tex_be inside {4'h3, 4'hC})
        else $error("2-wide 8-bit map wrote upper texels");

    // coordinate decode; the three s layouts share one mux
    seq_decode_a: assert property (
        st.dp_tex && tx.fmt8 && tx.seq8
        |-> tx.s == {st.dp_addr[texld_pkg::S_LO +: 6], 2'h0})
        else $error("sequential 8-bit s field decoded wrongly");

    legacy_seq_a: assert property (
        st.dp_tex && tx.fmt8 && st.init_b[texld_pkg::INIT_B_LEGACY]
        |-> tx.s == {st.dp_addr[texld_pkg::S_LO + 1 +: 6], 2'h0})
        else $error("legacy part used the sequential layout");

    s_even_a: assert property (
        st.dp_tex && !tx.fmt8
        |-> !tx.s[0])
        else $error("16-bit s kept its lane bit");

    // level starts worked out from the size table by hand
    lod8_8_a: assert property (
        st.dp_tex && tx.fmt8 && !tx.tsplit && tx.aspect == 2'h3 &&
        tx.lod == 4'h8 && tx.s == 8'h00 && tx.t == 8'h00
        |-> tx.word == {tx.base, 1'b0} + 21'h000AAF)
        else $error("8-bit lod 8 start is wrong");

    split_start_a: assert property (
        st.dp_tex && tx.fmt8 && tx.tsplit && !tx.lod_odd &&
        tx.aspect == 2'h3 && tx.lod == 4'h8 && tx.s == 8'h00 &&
        tx.t == 8'h00
        |-> tx.word == {tx.base, 1'b0} + 21'h00088A)
        else $error("split even levels start is wrong");

    // bus timing: only reads wait, dropped transfers cost nothing
    write_no_wait_a: assert property (
        take && hwrite
        |=> hreadyout)
        else $error("write inserted a wait state");

    refuse_no_wait_a: assert property (
        addr_valid && !take
        |=> hreadyout && !st.dp_act)
        else $error("dropped transfer held the bus");

    rdata_hold_a: assert property (
        !st.rd_wait
        |=> $stable(hrdata))
        else $error("read data changed outside a read");

    regs_hold_a: assert property (
        !(dp_done && st.dp_write && !st.dp_tex)
        |=> $stable(st.base) && $stable(st.mode))
        else $error("settings changed without a register write");

    tex16_c: cover property (tex_ok && !tx.fmt8);
    tex8_seq_c: cover property (tex_ok && tx.fmt8 && tx.seq8);
    narrow_c: cover property (tex_ok && tx.narrow == texld_pkg::NARROW_TWO);
    reg_read_c: cover property (st.rd_wait && !st.dp_tex ##1 hreadyout);
    slide_c: cover property (tex_ok && tx.byte_off != 2'h0);
endmodule

/* File: test/tb_texld_top.sv */
`timescale 1ns/100ps
module tb_texld_top;
    localparam logic [31:0] DATA = 32'hA5C396E1;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic hsel, hwrite, hready, hresp, io, tex_we, tex_half;
    logic [23:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, tex_data;
    logic [19:0] tex_addr;
    logic [3:0] tex_be;
    logic [56:0] cap = '0;
    int n_fail = 0;
    int total_checks = 0;
    int n_we = 0;

    always #5 clock = ~clock;

    // single slave: its hreadyout is the bus hready
    texld_top dut (.clock(clock), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .host_io_cycle(io),
        .tex_we(tex_we), .tex_addr(tex_addr), .tex_half(tex_half),
        .tex_be(tex_be), .tex_data(tex_data));

    texld_host host (.clock(clock), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .host_io_cycle(io), .hready(hready), .hrdata(hrdata));

    // count texel pulses and keep what the last one carried
    always @(posedge clock) begin
        if (tex_we === 1'h1) begin
            n_we++;
            cap = {tex_addr, tex_half, tex_be, tex_data};
        end
    end

    task automatic close_out();
        n_fail = n_fail + host.stuck;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // compare; a hung bus wait ends the run at the next check
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                seen, exp);
        end
        if (host.stuck != 0) begin
            close_out();
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(a, 1'h1, 1'h0, d, q);
    endtask

    task automatic rd_chk(input logic [23:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.xfer(a, 1'h0, 1'h0, 32'h00000000, q);
        chk({32'h00000000, q}, {32'h00000000, exp});
        chk({63'h0, hresp}, 64'h0);
    endtask

    // texture window byte address from unit, lod, t and s field
    function automatic logic [23:0] ta(input logic [1:0] u,
            input logic [3:0] l, input logic [7:0] t, input logic [6:0] s);
        return {1'h1, u, l, t, s, 2'h0};
    endfunction

    function automatic logic [56:0] ex(input logic [19:0] a,
            input logic h, input logic [3:0] be);
        return {a, h, be, DATA};
    endfunction

    // all offset parameters settle before any texel traffic
    task automatic cfg(input logic [19:0] b, input logic [8:0] m,
            input logic lg);
        wr(texld_pkg::OFS_BASE, {12'h000, b});
        wr(texld_pkg::OFS_MODE, {23'h000000, m});
        wr(texld_pkg::OFS_INIT_A, 32'h00000000);
        wr(texld_pkg::OFS_INIT_B, {31'h00000000, lg});
    endtask

    // one texel write; cnt pulses expected, carrying exp when one
    task automatic texw(input logic [23:0] a, input logic i,
            input int cnt, input logic [56:0] exp);
        int n0;
        logic [31:0] q;
        n0 = n_we;
        host.xfer(a, 1'h1, i, DATA, q);
        repeat (2) @(posedge clock);
        chk(64'(n_we - n0), 64'(cnt));
        if (cnt != 0) begin
            chk({7'h00, cap}, {7'h00, exp});
        end
    endtask

    // reset values, unmapped and write-only places
    task automatic sc_regs();
        rd_chk(texld_pkg::OFS_BASE, 32'h00000000);
        rd_chk(24'h800000, 32'h00000000);
        rd_chk(24'h000018, 32'h00000000);
        wr(texld_pkg::OFS_MODE, 32'h000001FF);
        rd_chk(texld_pkg::OFS_MODE, 32'h000001FF);
    endtask

    // 16-bit texels: level table, small map, one-wide lanes
    task automatic sc_16();
        cfg(20'h00010, 9'h000, 1'h0);
        texw(ta(2'h0, 4'h1, 8'h02, 7'h02), 1'h0, 1,
            ex(20'h04051, 1'h0, 4'hF));
        texw(ta(2'h0, 4'h8, 8'h00, 7'h00), 1'h0, 1,
            ex(20'h05565, 1'h0, 4'h3));
        cfg(20'hFC010, 9'h000, 1'h0);
        texw(ta(2'h0, 4'h1, 8'h00, 7'h00), 1'h0, 1,
            ex(20'h00010, 1'h0, 4'hF));
        // 1-wide rows share a word: odd row lands in the upper half
        cfg(20'h00010, 9'h030, 1'h0);
        texw(ta(2'h0, 4'h5, 8'h01, 7'h00), 1'h0, 1,
            {20'h00AB8, 1'h0, 4'hC, 32'h96E10000});
    endtask

    // 8-bit texels at 8:1, s wider, plain then split levels
    task automatic sc_8bit();
        cfg(20'h0FAB0, 9'h071, 1'h0);
        texw(ta(2'h0, 4'h4, 8'h00, 7'h00), 1'h0, 1,
            ex(20'h10000, 1'h0, 4'hF));
        texw(ta(2'h0, 4'h7, 8'h00, 7'h00), 1'h0, 1,
            ex(20'h10007, 1'h0, 4'h3));
        texw(ta(2'h0, 4'h8, 8'h00, 7'h00), 1'h0, 1,
            ex(20'h10007, 1'h1, 4'h1));
        cfg(20'h0FBC0, 9'h079, 1'h0);
        texw(ta(2'h0, 4'h8, 8'h00, 7'h00), 1'h0, 1,
            ex(20'h10005, 1'h0, 4'h1));
    endtask

    // sequential against plain 8-bit decode, and the legacy part
    task automatic sc_seq();
        cfg(20'h00000, 9'h003, 1'h0);
        texw(ta(2'h0, 4'h0, 8'h01, 7'h01), 1'h0, 1,
            ex(20'h00020, 1'h1, 4'hF));
        cfg(20'h00000, 9'h001, 1'h0);
        texw(ta(2'h0, 4'h0, 8'h01, 7'h01), 1'h0, 1,
            ex(20'h00020, 1'h0, 4'hF));
        cfg(20'h00000, 9'h003, 1'h1);
        texw(ta(2'h0, 4'h0, 8'h01, 7'h01), 1'h0, 1,
            ex(20'h00020, 1'h0, 4'hF));
    endtask

    // dropped writes leave the count and last address alone
    task automatic sc_refuse();
        texw(ta(2'h0, 4'h0, 8'h00, 7'h00), 1'h1, 0, '0);
        texw(ta(2'h1, 4'h0, 8'h00, 7'h00), 1'h0, 0, '0);
        rd_chk(texld_pkg::OFS_STATUS, 32'h0000000B);
        rd_chk(texld_pkg::OFS_LAST, 32'h00000040);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'h1;
        sc_regs();
        sc_16();
        sc_8bit();
        sc_seq();
        sc_refuse();
        close_out();
    end
endmodule

/* File: test/texld_host.sv */
`timescale 1ns/100ps
// host side bus master; owns the request lines
module texld_host (
    input wire logic clock,
    output logic hsel,
    output logic [23:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic host_io_cycle,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    int stuck = 0;

    // idle bus from time zero
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata, host_io_cycle} = '0;

    // wait for hready at an edge; bounded so a hang is seen
    task automatic wait_rdy();
        int n = 0;
        @(posedge clock);
        while (hready !== 1'h1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n >= 20) begin
            stuck++;
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic xfer(input logic [23:0] a, input logic w, input logic io,
            input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'h1;
        haddr <= {a[23:2], 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= texld_pkg::HSIZE_WORD;
        host_io_cycle <= io;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        // released data lines flip so stale values never look valid
        hwdata <= ~d;
    endtask
endmodule
